// file: verilog/rsa_regs.vh
`ifndef RSA_REGS_VH
`define RSA_REGS_VH

// structure access kinds carried on req_op_i
`define RSA_OP_W             4
`define RSA_OP_ROOT_RD       4'h0
`define RSA_OP_CTX_RD        4'h1
`define RSA_OP_PDIR_RD       4'h2
`define RSA_OP_PTBL_RD       4'h3
`define RSA_OP_FS_RD         4'h4
`define RSA_OP_FS_ATOM       4'h5
`define RSA_OP_SS_RD         4'h6
`define RSA_OP_SS_ATOM       4'h7
`define RSA_OP_IRT_RD        4'h8
`define RSA_OP_PID_ATOM      4'h9
`define RSA_OP_IQ_RD         4'hA
`define RSA_OP_PRQ_WR        4'hB
`define RSA_OP_IWAIT_WR      4'hC

// memory type encoding on the fabric
`define RSA_MT_W             3
`define RSA_MT_UC            3'h0
`define RSA_MT_WB            3'h6

// request address width
`define RSA_ADDR_W           64

// access direction codes
`define RSA_DIR_RD           2'h0
`define RSA_DIR_WR           2'h1
`define RSA_DIR_ATOM         2'h2

// reset values
`define RSA_RST_SNOOP        1'b0
`define RSA_RST_READY        1'b1

`endif

// file: verilog/rsa_sync3.v
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two and three agree
module rsa_sync3 (
  input  wire clk_i,     // device clock
  input  wire rst_n_i,   // async reset, active low
  input  wire d_i,       // asynchronous level
  output reg  q_o        // filtered synchronous level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule // rsa_sync3

// file: verilog/rsa_attr.v
`timescale 1ns/1ps
`include "rsa_regs.vh"

module rsa_attr (
  input  wire                      clk_i,                       // 40 MHz device clock
  input  wire                      rst_n_i,                     // async reset, active low
  input  wire                      coherency_capability_bit_i,  // capability strap, asynchronous
  input  wire                      scalable_mode_i,             // translation mode, asynchronous
  input  wire                      req_valid_i,                 // engine request valid
  input  wire [`RSA_OP_W-1:0]      req_op_i,                    // structure access kind
  input  wire [`RSA_ADDR_W-1:0]    req_addr_i,                  // structure address
  input  wire                      page_walk_snoop_field_i,     // page-walk snoop of governing entry
  output reg                       req_ready_o,                 // slot free, request taken
  output reg                       fab_valid_o,                 // access valid to fabric
  input  wire                      fab_ready_i,                 // fabric accepts access
  output reg  [`RSA_OP_W-1:0]      fab_op_o,                    // access kind echoed
  output reg  [`RSA_ADDR_W-1:0]    fab_addr_o,                  // access address
  output reg  [1:0]                fab_dir_o,                   // read, write or atomic
  output reg                       fab_snoop_o,                 // snoop attribute
  output reg  [`RSA_MT_W-1:0]      fab_mtype_o,                 // memory type
  output reg                       op_err_o                     // unknown access kind seen, sticky
);

  wire coh_cap;
  wire scal_mode;

  // both levels come from outside the clock domain
  rsa_sync3 u_sync_coh (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (coherency_capability_bit_i),
    .q_o     (coh_cap)
  );

  rsa_sync3 u_sync_mode (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (scalable_mode_i),
    .q_o     (scal_mode)
  );

  // returns {known, snoop}
  function [1:0] rsa_snoop_of;
    input [`RSA_OP_W-1:0] op;
    input                 cap;
    input                 mode;
    input                 page_walk_snoop_field;
    begin
      case (op)
        `RSA_OP_ROOT_RD:  rsa_snoop_of = {1'b1, cap};
        `RSA_OP_CTX_RD:   rsa_snoop_of = {1'b1, cap};
        `RSA_OP_PDIR_RD:  rsa_snoop_of = {1'b1, cap};
        `RSA_OP_PTBL_RD:  rsa_snoop_of = {1'b1, cap};
        `RSA_OP_FS_RD:    rsa_snoop_of = {1'b1, page_walk_snoop_field};
        `RSA_OP_FS_ATOM:  rsa_snoop_of = 2'b11;
        `RSA_OP_SS_RD:    rsa_snoop_of = {1'b1, mode ? page_walk_snoop_field : cap};
        `RSA_OP_SS_ATOM:  rsa_snoop_of = 2'b11;
        `RSA_OP_IRT_RD:   rsa_snoop_of = {1'b1, cap};
        `RSA_OP_PID_ATOM: rsa_snoop_of = 2'b11;
        `RSA_OP_IQ_RD:    rsa_snoop_of = 2'b11;
        `RSA_OP_PRQ_WR:   rsa_snoop_of = 2'b11;
        `RSA_OP_IWAIT_WR: rsa_snoop_of = 2'b11;
        // unknown kinds still go out snooped, the safe choice for coherency
        default:          rsa_snoop_of = 2'b01;
      endcase
    end
  endfunction

  function [1:0] rsa_dir_of;
    input [`RSA_OP_W-1:0] op;
    begin
      case (op)
        `RSA_OP_FS_ATOM,
        `RSA_OP_SS_ATOM,
        `RSA_OP_PID_ATOM: rsa_dir_of = `RSA_DIR_ATOM;
        `RSA_OP_PRQ_WR,
        `RSA_OP_IWAIT_WR: rsa_dir_of = `RSA_DIR_WR;
        default:          rsa_dir_of = `RSA_DIR_RD;
      endcase
    end
  endfunction

  // every kind is write-back today; a per-kind table keeps a future exception to one line
  function [`RSA_MT_W-1:0] rsa_mtype_of;
    input [`RSA_OP_W-1:0] op;
    begin
      case (op)
        `RSA_OP_ROOT_RD:  rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_CTX_RD:   rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_PDIR_RD:  rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_PTBL_RD:  rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_FS_RD:    rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_FS_ATOM:  rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_SS_RD:    rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_SS_ATOM:  rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_IRT_RD:   rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_PID_ATOM: rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_IQ_RD:    rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_PRQ_WR:   rsa_mtype_of = `RSA_MT_WB;
        `RSA_OP_IWAIT_WR: rsa_mtype_of = `RSA_MT_WB;
        // unknown kinds go out write-back too, in line with their forced snoop
        default:          rsa_mtype_of = `RSA_MT_WB;
      endcase
    end
  endfunction

  // slot states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  wire [1:0]             attr      = rsa_snoop_of(req_op_i, coh_cap, scal_mode, page_walk_snoop_field_i);
  // snoop choice and kind check come from one decode so they never disagree
  wire                   snoop_sel = attr[0];
  wire                   op_known  = attr[1];
  // both handshakes complete on a rising edge with valid and ready high
  wire                   take      = req_valid_i & req_ready_o;
  wire                   drain     = fab_valid_o & fab_ready_i;

  // next values of every output flop
  reg  [1:0]             state_reg;
  reg  [1:0]             state_next;
  reg                    fab_valid_next;
  reg                    req_ready_next;
  reg  [`RSA_OP_W-1:0]   fab_op_next;
  reg  [`RSA_ADDR_W-1:0] fab_addr_next;
  reg  [1:0]             fab_dir_next;
  reg                    fab_snoop_next;
  reg  [`RSA_MT_W-1:0]   fab_mtype_next;
  reg                    op_err_next;

  // single slot: take only from idle, drain only from busy, so both never meet in one cycle
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (drain) begin
          state_next = ST_IDLE;
        end
      end
      // an upset state falls back to idle rather than hanging the walk engines
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    fab_valid_next = state_next[1];
    // ready follows the slot state of the coming cycle, which costs one cycle between accesses
    req_ready_next = state_next[0];
  end

  // the fields latch only on take and then stand until the fabric drains the slot
  always @* begin
    fab_op_next    = fab_op_o;
    fab_addr_next  = fab_addr_o;
    fab_dir_next   = fab_dir_o;
    fab_snoop_next = fab_snoop_o;
    fab_mtype_next = fab_mtype_o;
    op_err_next    = op_err_o;
    if (take) begin
      fab_op_next    = req_op_i;
      fab_addr_next  = req_addr_i;
      fab_dir_next   = rsa_dir_of(req_op_i);
      fab_snoop_next = snoop_sel;
      fab_mtype_next = rsa_mtype_of(req_op_i);
      // sticky: only reset clears it, so a bad kind stays visible after later good ones
      if (!op_known) begin
        op_err_next = 1'b1;
      end
    end
  end

  // control flops; the handshake outputs come straight from these
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      req_ready_o <= `RSA_RST_READY;
      fab_valid_o <= 1'b0;
    end else begin
      state_reg   <= state_next;
      req_ready_o <= req_ready_next;
      fab_valid_o <= fab_valid_next;
    end
  end

  // access fields; uncached type after reset until the first take
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fab_op_o    <= `RSA_OP_ROOT_RD;
      fab_addr_o  <= {`RSA_ADDR_W{1'b0}};
      fab_dir_o   <= `RSA_DIR_RD;
      fab_snoop_o <= `RSA_RST_SNOOP;
      fab_mtype_o <= `RSA_MT_UC;
      op_err_o    <= 1'b0;
    end else begin
      fab_op_o    <= fab_op_next;
      fab_addr_o  <= fab_addr_next;
      fab_dir_o   <= fab_dir_next;
      fab_snoop_o <= fab_snoop_next;
      fab_mtype_o <= fab_mtype_next;
      op_err_o    <= op_err_next;
    end
  end

endmodule // rsa_attr

// file: verif/rsa_attr_checker.sv
`timescale 1ns/1ps
module rsa_attr_checker (
  input wire logic       clk_i, rst_n_i, coherency_capability_bit_i, scalable_mode_i, req_valid_i,
  input wire logic       page_walk_snoop_field_i, req_ready_o, fab_valid_o, fab_ready_i, fab_snoop_o,
  input wire logic [3:0] req_op_i, fab_op_o,
  input wire logic [1:0] fab_dir_o,
  input wire logic [2:0] fab_mtype_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take; req_valid_i && req_ready_o; endsequence
  sequence s_wb; fab_valid_o && fab_mtype_o == 3'h6; endsequence
  a_fixed_snoop: assert property (fab_valid_o && fab_op_o inside {4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC}
    |-> s_wb ##0 fab_snoop_o) else $error("fixed access not snooped wb");
  a_cap_snoop: assert property (fab_valid_o && fab_op_o inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8}
    |-> s_wb ##0 fab_snoop_o == coherency_capability_bit_i) else $error("capability snoop wrong");
  a_fs_snoop: assert property (s_take ##0 req_op_i == 4'h4
    |=> s_wb ##0 fab_snoop_o == $past(page_walk_snoop_field_i)) else $error("first-stage snoop wrong");
  a_ss_snoop: assert property (s_take ##0 req_op_i == 4'h6 |=> s_wb ##0 fab_snoop_o ==
    (scalable_mode_i ? $past(page_walk_snoop_field_i) : coherency_capability_bit_i)) else $error("ss snoop wrong");
  a_answer_next: assert property (s_take |=> fab_valid_o && !req_ready_o && fab_op_o == $past(req_op_i))
    else $error("access not issued next cycle");
  a_hold_stable: assert property (fab_valid_o && !fab_ready_i |=> fab_valid_o && $stable(fab_snoop_o))
    else $error("access dropped before accept");
  a_atomic_dir: assert property (fab_valid_o && fab_op_o inside {4'h5, 4'h7, 4'h9} |-> fab_dir_o == 2'h2)
    else $error("atomic direction wrong");
  a_write_dir: assert property (fab_valid_o && fab_op_o inside {4'hB, 4'hC} |-> fab_dir_o == 2'h1)
    else $error("write direction wrong");
endmodule // rsa_attr_checker

// file: verif/rsa_fab_model.sv
`timescale 1ns/1ps
module rsa_fab_model (
  input  wire       clk_i,       // device clock
  input  wire       fab_valid_o, // access offered
  input  wire [3:0] stall_i,     // wait cycles before accept
  output reg        fab_ready_i  // accept strobe
);
  reg [3:0] cnt_reg = 4'h0;
  initial fab_ready_i = 1'b0;
  // accept is a one-cycle strobe so a stale accept never swallows the next access
  always @(negedge clk_i) begin
    fab_ready_i <= 1'b0;
    if (!fab_valid_o) cnt_reg <= 4'h0;
    else if (cnt_reg == stall_i && !fab_ready_i) fab_ready_i <= 1'b1;
    else if (!fab_ready_i) cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // rsa_fab_model

// file: verif/tb_remap_structure_access_attributes.sv
`timescale 1ns/1ps
module tb_remap_structure_access_attributes;
  reg clk_i = 0, rst_n_i = 0, cap = 0, mode = 0, rv = 0, pw = 0;
  reg  [3:0]  op = 4'h0, stall = 4'h0;
  wire        rr, fv, fr, sn, err;
  wire [3:0]  fo;
  wire [1:0]  fd;
  wire [2:0]  mt;
  wire [63:0] fa;
  integer error_cnt = 0, tests_run = 0, n;
  initial forever #12.5 clk_i = ~clk_i;
  rsa_attr uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .coherency_capability_bit_i(cap), .scalable_mode_i(mode),
    .req_valid_i(rv), .req_op_i(op), .req_addr_i({60'h0, op}), .page_walk_snoop_field_i(pw), .req_ready_o(rr),
    .fab_valid_o(fv), .fab_ready_i(fr), .fab_op_o(fo), .fab_addr_o(fa), .fab_dir_o(fd), .fab_snoop_o(sn),
    .fab_mtype_o(mt), .op_err_o(err));
  rsa_fab_model fab (.clk_i(clk_i), .fab_valid_o(fv), .stall_i(stall), .fab_ready_i(fr));
  task check(input [63:0] s, input [63:0] e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  end endtask
  task tally_and_finish; begin
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  task wait_ready; begin
    n = 0;
    while (rr !== 1'b1 && n < 50) begin @(negedge clk_i); n = n + 1; end
    if (n >= 50) begin error_cnt = error_cnt + 1; tally_and_finish; end
  end endtask
  task send(input [3:0] o, input p); reg es; begin
    wait_ready;
    op = o; pw = p; rv = 1; @(negedge clk_i); rv = 0;
    es = (o < 4'h4 || o == 4'h8) ? cap : (o == 4'h4 || (o == 4'h6 && mode)) ? p : (o == 4'h6) ? cap : 1'b1;
    check({fv, rr, sn, mt, fd, fo}, {2'b10, es, 3'h6, (o == 4'h5 || o == 4'h7 || o == 4'h9) ? 2'h2 :
      (o == 4'hB || o == 4'hC) ? 2'h1 : 2'h0, o});
    wait_ready;
  end endtask
  task t_sweep(input m); integer c, k; begin
    mode = m;
    for (c = 0; c < 2; c = c + 1) begin
      cap = c;
      repeat (6) @(negedge clk_i);
      for (k = 0; k < 13; k = k + 1) send(k[3:0], ~cap);
    end
  end endtask
  task t_stall; begin
    wait_ready;
    stall = 4'h3;
    op = 4'hA;
    rv = 1;
    @(negedge clk_i);
    op = 4'hB;
    repeat (2) @(negedge clk_i);
    // the write waits behind the stalled fetch and must not overwrite it
    check({fo, rr, fv, sn, fa[7:0]}, {4'hA, 2'b01, 1'b1, 8'h0A});
    wait_ready;
    @(negedge clk_i);
    rv = 0;
    check({fo, fv, sn, mt, fd, fa[7:0]}, {4'hB, 1'b1, 1'b1, 3'h6, 2'h1, 8'h0B});
    wait_ready;
    stall = 4'h0;
  end endtask
  task t_bad; begin
    check(err, 1'b0);
    send(4'hF, 1'b0);
    check(err, 1'b1);
  end endtask
  task t_reset; begin
    rst_n_i = 0;
    @(negedge clk_i);
    check({rr, fv, sn, mt, err}, {3'b100, 3'h0, 1'b0});
    rst_n_i = 1;
    repeat (6) @(negedge clk_i);
    send(4'h0, 1'b0);
    check(err, 1'b0);
  end endtask
  initial begin
    repeat (2) @(negedge clk_i);
    check({rr, fv, err}, 3'h4);
    rst_n_i = 1;
    t_sweep(1'b0); t_sweep(1'b1); t_stall; t_bad; t_reset;
    tally_and_finish;
  end
endmodule // tb_remap_structure_access_attributes
bind rsa_attr rsa_attr_checker chk (.*);
